// *** design/mdiou_user_access.sv ***
// The AHB-Lite slave port and the address map are this design's own decisions.
`timescale 1ns/100ps
`default_nettype none
module mdiou_user_access
	import mdiou_pkg::*;
(
	input wire logic ref_clk_i,
	input wire logic sys_rst_i,
	input wire logic hsel_i,
	input wire logic [31:0] haddr_i,
	input wire logic [1:0] htrans_i,
	input wire logic hwrite_i,
	input wire logic [2:0] hsize_i,
	input wire logic [31:0] hwdata_i,
	input wire logic hready_i,
	output logic hreadyout_o,
	output logic hresp_o,
	output logic [31:0] hrdata_o,
	output logic irq_o,
	output logic mdc_o,
	input wire logic mdio_i,
	output logic mdio_o,
	output logic mdio_oe_o
);

	// ----------------------------------------------------------------
	// Declarations
	// ----------------------------------------------------------------
	mdiou_state_t state_r;
	mdiou_cmd_t cmd_r;
	mdiou_lsel_t lsel_r;
	mdiou_evt_t status_r;
	mdiou_evt_t mask_r;
	mdiou_evt_t status_nxt;
	logic go_r;
	logic ctrl_en_r;
	logic cur_user_r;
	logic [5:0] bit_cnt_r;
	logic [63:0] tx_r;
	logic [15:0] rx_r;
	logic ack_r;
	logic mdio_r;
	logic oe_r;
	logic link_r;
	logic link_valid_r;
	logic dph_wr_r;
	logic [7:0] dph_addr_r;
	logic [31:0] hrdata_r;
	logic mdio_s;
	logic rise;
	logic fall;

	// ----------------------------------------------------------------
	// Clock divider and input synchroniser
	// ----------------------------------------------------------------
	mdiou_mdc_div u_div (
		.ref_clk_i(ref_clk_i),
		.sys_rst_i(sys_rst_i),
		.mdc_o(mdc_o),
		.rise_o(rise),
		.fall_o(fall)
	);

	mdiou_sync2 u_sync (
		.ref_clk_i(ref_clk_i),
		.sys_rst_i(sys_rst_i),
		.async_i(mdio_i),
		.sync_o(mdio_s)
	);

	// ----------------------------------------------------------------
	// Bus decode
	// ----------------------------------------------------------------
	// Upper address bits are left to the system decoder behind hsel
	wire addr_ok = hsel_i && htrans_i[1] && hready_i;
	wire rd_fire = addr_ok && !hwrite_i;
	wire wr_take = addr_ok && hwrite_i && (hsize_i == SIZE_WORD);
	wire [7:0] a_ofs = haddr_i[7:0];
	wire wr_ctrl = dph_wr_r && (dph_addr_r == OFS_CTRL);
	wire wr_lsel = dph_wr_r && (dph_addr_r == OFS_LINK_SOURCE_SELECT);
	wire wr_cmd = dph_wr_r && (dph_addr_r == OFS_CMD1);
	wire wr_mask = dph_wr_r && (dph_addr_r == OFS_MASK);
	wire wr_mclr = dph_wr_r && (dph_addr_r == OFS_MASKCLR);
	wire stat_rd = rd_fire && (a_ofs == OFS_STAT);

	// Read view of each register; reserved bits read as zero
	wire [31:0] rd_ctrl = {31'h0000_0000, ctrl_en_r};
	wire [31:0] rd_lsel = {24'h00_0000, lsel_r.link_source_select,
		lsel_r.link_change_irq_enable, 1'b0, lsel_r.monitored_phy_index};
	wire [31:0] rd_cmd = {go_r, cmd_r.write_op, cmd_r.ack, 3'h0,
		cmd_r.phy_register_index, cmd_r.target_phy_index, cmd_r.data};
	wire [31:0] rd_stat = {30'h0000_0000, status_r};
	wire [31:0] rd_mask = {30'h0000_0000, mask_r};
	wire [31:0] rd_link = {31'h0000_0000, link_r};
	wire [31:0] rd_mux =
		(a_ofs == OFS_CTRL) ? rd_ctrl :
		(a_ofs == OFS_LINK_SOURCE_SELECT) ? rd_lsel :
		(a_ofs == OFS_CMD1) ? rd_cmd :
		(a_ofs == OFS_STAT) ? rd_stat :
		(a_ofs == OFS_MASK) ? rd_mask :
		(a_ofs == OFS_LINK) ? rd_link : 32'h0000_0000;

	// Always ready, always OKAY: every register answers in one cycle
	assign hreadyout_o = 1'b1;
	assign hresp_o = 1'b0;
	assign hrdata_o = hrdata_r;

	// Address phase capture; read data registered for the data phase
	always_ff @(posedge ref_clk_i) begin
		if (sys_rst_i) begin
			dph_wr_r <= 1'b0;
			dph_addr_r <= 8'h00;
			hrdata_r <= 32'h0000_0000;
		end else begin
			dph_wr_r <= wr_take;
			dph_addr_r <= a_ofs;
			hrdata_r <= rd_fire ? rd_mux : 32'h0000_0000;
		end
	end

	// ----------------------------------------------------------------
	// Frame engine decode
	// ----------------------------------------------------------------
	wire in_frame = (state_r == ST_FRAME);
	wire frame_done = (state_r == ST_DONE);
	wire user_done = frame_done && cur_user_r;
	wire poll_done = frame_done && !cur_user_r;
	// User command beats polling; starts only on a falling edge
	wire frame_start = (state_r == ST_IDLE) && fall && ctrl_en_r;
	wire pick_user = go_r;
	wire [4:0] f_phy = pick_user ? cmd_r.target_phy_index :
		lsel_r.monitored_phy_index;
	wire [4:0] f_reg = pick_user ? cmd_r.phy_register_index : POLL_REG;
	wire f_wr = pick_user && cmd_r.write_op;
	wire [15:0] f_data = f_wr ? cmd_r.data : 16'hffff;
	wire [63:0] f_bits = {PREAMBLE, SOF_CODE, f_wr ? OP_WR : OP_RD,
		f_phy, f_reg, f_wr ? TA_WR : TA_RD, f_data};
	wire [5:0] next_idx = bit_cnt_r + 6'h01;
	wire cur_wr = cur_user_r && cmd_r.write_op;
	// Reads hand the line to the PHY from the turnaround onward
	wire drive_next = (next_idx < TA_FIRST_IDX) || cur_wr;
	wire last_rise = in_frame && rise && (bit_cnt_r == FRAME_LAST);

	// State sequence: idle, one frame of 64 clocks, one done cycle
	always_ff @(posedge ref_clk_i) begin
		if (sys_rst_i) begin
			state_r <= ST_IDLE;
			cur_user_r <= 1'b0;
		end else begin
			unique case (state_r)
				ST_IDLE: begin
					if (frame_start) begin
						state_r <= ST_FRAME;
						cur_user_r <= pick_user;
					end
				end
				ST_FRAME: begin
					if (last_rise) begin
						state_r <= ST_DONE;
					end
				end
				ST_DONE: begin
					state_r <= ST_IDLE;
				end
			endcase
		end
	end

	// Shift out on falling edges so the PHY samples stable rising edges
	always_ff @(posedge ref_clk_i) begin
		if (sys_rst_i) begin
			tx_r <= 64'h0000_0000_0000_0000;
			bit_cnt_r <= 6'h00;
			mdio_r <= 1'b1;
			oe_r <= 1'b0;
		end else if (frame_start) begin
			tx_r <= f_bits;
			bit_cnt_r <= 6'h00;
			mdio_r <= f_bits[63];
			oe_r <= 1'b1;
		end else if (in_frame && fall) begin
			tx_r <= {tx_r[62:0], 1'b1};
			bit_cnt_r <= next_idx;
			mdio_r <= tx_r[62];
			oe_r <= drive_next;
		end else if (frame_done) begin
			oe_r <= 1'b0;
			mdio_r <= 1'b1;
		end
	end

	assign mdio_o = mdio_r;
	assign mdio_oe_o = oe_r;

	// Sample the PHY on rising edges; low in second TA bit is the ack
	always_ff @(posedge ref_clk_i) begin
		if (sys_rst_i) begin
			rx_r <= 16'h0000;
			ack_r <= 1'b0;
		end else if (frame_start) begin
			ack_r <= 1'b0;
		end else if (in_frame && rise) begin
			if (bit_cnt_r == TA_ACK_IDX) begin
				ack_r <= !mdio_s;
			end
			if (bit_cnt_r >= DATA_FIRST_IDX) begin
				rx_r <= {rx_r[14:0], mdio_s};
			end
		end
	end

	// ----------------------------------------------------------------
	// Command register and go flag
	// ----------------------------------------------------------------
	wire cmd_open = wr_cmd && !go_r;
	wire go_set = cmd_open && ctrl_en_r && hwdata_i[GO_BIT];

	// Fields are frozen while go is set, so the running frame is safe
	always_ff @(posedge ref_clk_i) begin
		if (sys_rst_i) begin
			cmd_r <= '0;
		end else if (user_done) begin
			cmd_r.ack <= !cmd_r.write_op && ack_r;
			if (!cmd_r.write_op) begin
				cmd_r.data <= rx_r;
			end
		end else if (cmd_open) begin
			cmd_r.write_op <= hwdata_i[WRITE_BIT];
			cmd_r.ack <= hwdata_i[ACK_BIT];
			cmd_r.phy_register_index <= hwdata_i[REG_LSB +: 5];
			cmd_r.target_phy_index <= hwdata_i[PHY_LSB +: 5];
			cmd_r.data <= hwdata_i[15:0];
		end
	end

	// Go is set by software, cleared only by completion
	always_ff @(posedge ref_clk_i) begin
		if (sys_rst_i) begin
			go_r <= 1'b0;
		end else if (user_done) begin
			go_r <= 1'b0;
		end else if (go_set) begin
			go_r <= 1'b1;
		end
	end

	// ----------------------------------------------------------------
	// Control, link select and link monitor
	// ----------------------------------------------------------------
	// Disabling mid-frame lets the frame finish; no new frame starts
	always_ff @(posedge ref_clk_i) begin
		if (sys_rst_i) begin
			ctrl_en_r <= CTRL_EN_RST;
			lsel_r <= '0;
		end else begin
			if (wr_ctrl) begin
				ctrl_en_r <= hwdata_i[CTRL_EN_BIT];
			end
			if (wr_lsel) begin
				// Source bit is stored only; polling is the sole source
				lsel_r.link_source_select <= hwdata_i[LSEL_SRC_BIT];
				lsel_r.link_change_irq_enable <= hwdata_i[LSEL_IRQEN_BIT];
				lsel_r.monitored_phy_index <= hwdata_i[MON_LSB +: 5];
			end
		end
	end

	// No ack from the polled PHY counts as link down
	wire link_now = ack_r && rx_r[LINK_STAT_BIT];
	wire link_evt = poll_done && link_valid_r && (link_now != link_r) &&
		lsel_r.link_change_irq_enable;

	// First poll after a select change only seeds the reference level
	always_ff @(posedge ref_clk_i) begin
		if (sys_rst_i) begin
			link_r <= 1'b0;
			link_valid_r <= 1'b0;
		end else if (wr_lsel) begin
			link_valid_r <= 1'b0;
		end else if (poll_done) begin
			link_r <= link_now;
			link_valid_r <= 1'b1;
		end
	end

	// ----------------------------------------------------------------
	// Interrupts
	// ----------------------------------------------------------------
	wire mdiou_evt_t evt_set = '{link_chg: link_evt, cmd_done: user_done};
	wire mdiou_evt_t evt_clr = stat_rd ? status_r : '0;

	// A new event in the read cycle survives the read-clear
	assign status_nxt = (status_r & ~evt_clr) | evt_set;

	always_ff @(posedge ref_clk_i) begin
		if (sys_rst_i) begin
			status_r <= STAT_RST;
			mask_r <= MASK_RST;
		end else begin
			status_r <= status_nxt;
			if (wr_mask) begin
				mask_r <= hwdata_i[1:0];
			end else if (wr_mclr && hwdata_i[MASKCLR_CMD1_BIT]) begin
				mask_r.cmd_done <= 1'b0;
			end
		end
	end

	assign irq_o = |(status_r & mask_r);

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge ref_clk_i); endclocking
	default disable iff (sys_rst_i);

	sequence s_go_write_one;
		wr_cmd && !go_r && hwdata_i[GO_BIT];
	endsequence

	a_go_not_instant: assert property ($rose(go_r) |-> go_r [*8])
		else $error("go cleared too soon after being set");
	a_go_zero_write: assert property (
		wr_cmd && !go_r && !hwdata_i[GO_BIT] |=> !go_r)
		else $error("writing zero to go set it");
	a_go_needs_enable: assert property (
		s_go_write_one and !ctrl_en_r |=> !go_r)
		else $error("go set while engine disabled");
	a_go_self_clear: assert property (user_done |=> !go_r)
		else $error("go still set after completion");
	a_cmd_blocked: assert property (
		wr_cmd && go_r && !user_done |=> $stable(cmd_r))
		else $error("command fields changed while go set");
	a_read_releases: assert property (in_frame && !cur_wr &&
		bit_cnt_r >= TA_FIRST_IDX && !fall |-> !mdio_oe_o)
		else $error("line driven during read turnaround or data");
	a_write_drives: assert property (in_frame && cur_wr |-> mdio_oe_o)
		else $error("line released during write frame");
	a_ack_write_zero: assert property (
		user_done && cmd_r.write_op |=> !cmd_r.ack)
		else $error("ack set after a write command");
	a_preamble_ones: assert property (
		in_frame && bit_cnt_r < PRE_BITS |-> mdio_o && mdio_oe_o)
		else $error("preamble bit not driven high");
	a_frame_length: assert property (
		frame_start |=> in_frame [*8] ##1 in_frame [*8])
		else $error("frame ended early");
	a_done_status: assert property (user_done |=> status_r.cmd_done)
		else $error("completion did not set status");
	a_link_gated: assert property (poll_done &&
		!lsel_r.link_change_irq_enable && !status_r.link_chg
		|=> !status_r.link_chg)
		else $error("link event flagged while disabled");
	a_link_evt: assert property (poll_done && link_valid_r &&
		lsel_r.link_change_irq_enable && link_now != link_r
		|=> status_r.link_chg)
		else $error("link change not flagged");

endmodule : mdiou_user_access
`default_nettype wire

// *** design/mdiou_pkg.sv ***
// Summary of operation
// - Writing 1 to the go flag queues one access; the engine runs it later.
// - Writing 0 to the go flag changes nothing.
// - Go flag can only be set while the management engine is enabled.
// - Go flag clears itself once the bus access has fully completed.
// - Writes to the command register are dropped while go reads 1.
// - Bit 30 set means PHY register write, clear means PHY register read.
// - Bit 29 is set when the PHY acknowledged a read, clear otherwise.
// - Bits 25:21 give the PHY register index sent in the frame.
// - Bits 20:16 give the PHY address the frame targets.
// - Bits 15:0 carry write data out and take read data back.
// - Link source select bit 7 resets to 0; engine polling is the source.
// - Bit 6 enables link-change interrupts for the monitored PHY.
// - Bits 4:0 hold the PHY address whose link is monitored.
// - Command completion raises an interrupt only while its mask bit is set; the mask-clear bit clears it.
package mdiou_pkg;

	// ----------------------------------------------------------------
	// Register map
	// ----------------------------------------------------------------
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_LINK_SOURCE_SELECT = 8'h04;
	localparam logic [7:0] OFS_CMD1 = 8'h08;
	localparam logic [7:0] OFS_STAT = 8'h0c;
	localparam logic [7:0] OFS_MASK = 8'h10;
	localparam logic [7:0] OFS_MASKCLR = 8'h14;
	localparam logic [7:0] OFS_LINK = 8'h18;
	localparam logic [2:0] SIZE_WORD = 3'h2;

	// ----------------------------------------------------------------
	// Field positions
	// ----------------------------------------------------------------
	localparam int GO_BIT = 31;
	localparam int WRITE_BIT = 30;
	localparam int ACK_BIT = 29;
	localparam int REG_LSB = 21;
	localparam int PHY_LSB = 16;
	localparam int LSEL_SRC_BIT = 7;
	localparam int LSEL_IRQEN_BIT = 6;
	localparam int MON_LSB = 0;
	localparam int CTRL_EN_BIT = 0;
	localparam int MASKCLR_CMD1_BIT = 1;
	localparam int LINK_STAT_BIT = 2;

	// ----------------------------------------------------------------
	// Reset values
	// ----------------------------------------------------------------
	localparam logic CTRL_EN_RST = 1'b0;
	localparam logic [1:0] STAT_RST = 2'h0;
	localparam logic [1:0] MASK_RST = 2'h0;

	// ----------------------------------------------------------------
	// Timing: management clock from the 50 MHz reference
	// ----------------------------------------------------------------
	localparam int CLK_PERIOD_NS = 20;
	localparam int MDC_PERIOD_NS = 160;
	localparam logic [3:0] MDC_HALF_CYC =
		4'(MDC_PERIOD_NS / (2 * CLK_PERIOD_NS));

	// ----------------------------------------------------------------
	// Frame layout, bit indices from the first preamble bit
	// ----------------------------------------------------------------
	localparam logic [5:0] PRE_BITS = 6'h20;
	localparam logic [5:0] TA_FIRST_IDX = 6'h2e;
	localparam logic [5:0] TA_ACK_IDX = 6'h2f;
	localparam logic [5:0] DATA_FIRST_IDX = 6'h30;
	localparam logic [5:0] FRAME_LAST = 6'h3f;
	localparam logic [31:0] PREAMBLE = 32'hffff_ffff;
	localparam logic [1:0] SOF_CODE = 2'h1;
	localparam logic [1:0] OP_WR = 2'h1;
	localparam logic [1:0] OP_RD = 2'h2;
	localparam logic [1:0] TA_WR = 2'h2;
	localparam logic [1:0] TA_RD = 2'h3;
	localparam logic [4:0] POLL_REG = 5'h01;

	// ----------------------------------------------------------------
	// Types
	// ----------------------------------------------------------------
	typedef struct packed {
		logic write_op;
		logic ack;
		logic [4:0] phy_register_index;
		logic [4:0] target_phy_index;
		logic [15:0] data;
	} mdiou_cmd_t;

	typedef struct packed {
		logic link_source_select;
		logic link_change_irq_enable;
		logic [4:0] monitored_phy_index;
	} mdiou_lsel_t;

	typedef struct packed {
		logic link_chg;
		logic cmd_done;
	} mdiou_evt_t;

	typedef enum logic [1:0] {ST_IDLE, ST_FRAME, ST_DONE} mdiou_state_t;

endpackage : mdiou_pkg

// *** design/mdiou_sync2.sv ***
`timescale 1ns/100ps
`default_nettype none
module mdiou_sync2 (
	input wire logic ref_clk_i,
	input wire logic sys_rst_i,
	input wire logic async_i,
	output logic sync_o
);
	logic meta_r;
	logic sync_r;

	// Two stages; only the second stage is read outside
	always_ff @(posedge ref_clk_i) begin
		if (sys_rst_i) begin
			meta_r <= 1'b1;
			sync_r <= 1'b1;
		end else begin
			meta_r <= async_i;
			sync_r <= meta_r;
		end
	end

	assign sync_o = sync_r;
endmodule : mdiou_sync2
`default_nettype wire

// *** design/mdiou_mdc_div.sv ***
`timescale 1ns/100ps
`default_nettype none
module mdiou_mdc_div
	import mdiou_pkg::*;
(
	input wire logic ref_clk_i,
	input wire logic sys_rst_i,
	output logic mdc_o,
	output logic rise_o,
	output logic fall_o
);
	logic [3:0] cnt_r;
	logic mdc_r;
	wire flip = (cnt_r == MDC_HALF_CYC - 4'h1);

	// Free-running divider; the clock keeps toggling between frames
	always_ff @(posedge ref_clk_i) begin
		if (sys_rst_i) begin
			cnt_r <= 4'h0;
			mdc_r <= 1'b0;
		end else begin
			cnt_r <= flip ? 4'h0 : cnt_r + 4'h1;
			mdc_r <= flip ? !mdc_r : mdc_r;
		end
	end

	// Edge pulses are high in the cycle before the pin level changes, at the edge that ends it
	assign rise_o = flip && !mdc_r;
	assign fall_o = flip && mdc_r;
	assign mdc_o = mdc_r;
endmodule : mdiou_mdc_div
`default_nettype wire

// *** tb/mdiou_phy_model.sv ***
`timescale 1ns/100ps
`default_nettype none
// Behavioural PHY; answers only at its own address, line has a pull-up
module mdiou_phy_model
	import mdiou_pkg::*;
#(
	parameter logic [4:0] OWN_ADDR = 5'h05
) (
	input wire logic mdc_i,
	input wire logic line_i,
	input wire logic link_up_i,
	output logic oe_o,
	output logic d_o,
	output logic [12:0] hdr_o,
	output logic [17:0] tail_o,
	output var int bad_o
);
	logic [15:0] regs [32];
	logic [15:0] rdval;
	logic hit;
	int ones;
	int cnt;
	initial begin
		oe_o = 1'b0;
		d_o = 1'b1;
		bad_o = 0;
		hit = 1'b0;
		ones = 0;
		cnt = 0;
		foreach (regs[i]) regs[i] = 16'h0000;
	end
	// ------------------------------------------------------------
	// Frame decode on mdc rise, where the line is settled
	// ------------------------------------------------------------
	always @(posedge mdc_i) begin
		if (cnt == 0) begin
			if (line_i && ones < 64) ones = ones + 1;
			else if (!line_i && ones >= 32) cnt = 1;
			else if (!line_i) ones = 0;
		end else begin
			cnt = cnt + 1;
			if (cnt <= 14) hdr_o = {hdr_o[11:0], line_i};
			if (cnt >= 15) tail_o = {tail_o[16:0], line_i};
			if (cnt == 14) begin
				hit = hdr_o[9:5] == OWN_ADDR && hdr_o[11:10] == OP_RD;
				rdval = (hdr_o[4:0] == POLL_REG) ?
					16'(link_up_i) << LINK_STAT_BIT : regs[hdr_o[4:0]];
				if (hdr_o[12] !== 1'b1) bad_o++;
			end
			if (cnt == 32) begin
				if (hdr_o[11:10] == OP_WR && tail_o[17:16] !== TA_WR)
					bad_o++;
				if (hdr_o[11:10] == OP_WR && hdr_o[9:5] == OWN_ADDR)
					regs[hdr_o[4:0]] = tail_o[15:0];
				cnt = 0;
				ones = 0;
				hit = 1'b0;
			end
		end
	end
	// ------------------------------------------------------------
	// Read answer launched on mdc fall: TA low, then 16 bits
	// ------------------------------------------------------------
	always @(negedge mdc_i) begin
		oe_o = hit && cnt >= 15 && cnt <= 31;
		d_o = (cnt == 15) ? 1'b0 : rdval[4'(31 - cnt)];
	end
endmodule : mdiou_phy_model
`default_nettype wire

// *** tb/test_mdio_user_access_link_select.sv ***
`timescale 1ns/100ps
`default_nettype none
module test_mdio_user_access_link_select
	import mdiou_pkg::*;
;
	logic ref_clk_i, sys_rst_i, hsel_i, hwrite_i, hready;
	logic [31:0] haddr_i, hwdata_i, hrdata_o;
	logic [1:0] htrans_i;
	logic [2:0] hsize_i;
	logic hresp_o, irq_o, mdc_o, mdio_o, mdio_oe_o, line, phy_oe, phy_d;
	logic link_up;
	logic [12:0] hdr;
	logic [17:0] tail;
	int bad, err_count, num_checks, cycles;
	// Pull-up wins whenever nobody drives the line
	assign line = mdio_oe_o ? mdio_o : (phy_oe ? phy_d : 1'b1);
	mdiou_user_access DUT (.ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i),
		.hsel_i(hsel_i), .haddr_i(haddr_i), .htrans_i(htrans_i),
		.hwrite_i(hwrite_i), .hsize_i(hsize_i), .hwdata_i(hwdata_i),
		.hready_i(hready), .hreadyout_o(hready), .hresp_o(hresp_o),
		.hrdata_o(hrdata_o), .irq_o(irq_o), .mdc_o(mdc_o),
		.mdio_i(line), .mdio_o(mdio_o), .mdio_oe_o(mdio_oe_o));
	mdiou_phy_model u_phy (.mdc_i(mdc_o), .line_i(line),
		.link_up_i(link_up), .oe_o(phy_oe), .d_o(phy_d), .hdr_o(hdr),
		.tail_o(tail), .bad_o(bad));
	// ------------------------------------------------------------
	// Bench helpers
	// ------------------------------------------------------------
	task automatic conclude();
		$display("checks %0d mismatches %0d", num_checks, err_count);
		if (err_count == 0 && num_checks > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask : conclude
	task automatic chk(input string what, input logic [31:0] exp,
		input logic [31:0] got);
		num_checks++;
		if (got !== exp) begin
			err_count++;
			$display("BAD %s exp %h got %h", what, exp, got);
		end
	endtask : chk
	// Each phase held until ready is seen high at a rising edge; read
	// data is taken at the edge that ends the data phase
	task automatic xfer(input logic wr, input logic [7:0] a,
		input logic [31:0] wd, output logic [31:0] rd);
		hsel_i <= 1'b1;
		htrans_i <= 2'h2;
		haddr_i <= {24'h0, a};
		hwrite_i <= wr;
		hsize_i <= SIZE_WORD;
		@(posedge ref_clk_i);
		while (hready !== 1'b1) @(posedge ref_clk_i);
		htrans_i <= 2'h0;
		hwdata_i <= wd;
		@(posedge ref_clk_i);
		while (hready !== 1'b1) @(posedge ref_clk_i);
		rd = hrdata_o;
		chk("hresp", 32'h0, 32'(hresp_o));
	endtask : xfer
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] x;
		xfer(1'b1, a, d, x);
	endtask : wr
	task automatic rc(input string what, input logic [7:0] a,
		input logic [31:0] exp);
		logic [31:0] d;
		xfer(1'b0, a, 32'h0, d);
		chk(what, exp, d);
	endtask : rc
	task automatic wait_go();
		logic [31:0] d;
		int n;
		n = 0;
		d = 32'hffff_ffff;
		while (d[GO_BIT] !== 1'b0 && n < 1500) begin
			xfer(1'b0, OFS_CMD1, 32'h0, d);
			n++;
		end
		chk("go", 32'h0, 32'(d[GO_BIT]));
	endtask : wait_go
	// ------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------
	task automatic t_idle();
		rc("cmd rst", OFS_CMD1, 32'h0000_0000);
		rc("lsel rst", OFS_LINK_SOURCE_SELECT, 32'h0000_0000);
		rc("unmapped", 8'h1c, 32'h0000_0000);
		wr(OFS_CMD1, 32'h8005_1234);
		rc("go when off", OFS_CMD1, 32'h0005_1234);
		repeat (200) @(posedge ref_clk_i);
		chk("oe off", 32'h0, 32'(mdio_oe_o));
		chk("irq", 32'h0, 32'(irq_o));
		$display("t_idle done");
	endtask : t_idle
	task automatic t_write();
		wr(OFS_CTRL, 32'h0000_0001);
		wr(OFS_MASK, 32'h0000_0003);
		wr(OFS_CMD1, 32'hc065_a5c3);
		rc("queued", OFS_CMD1, 32'hc065_a5c3);
		wr(OFS_CMD1, 32'h0000_0000);
		rc("blocked", OFS_CMD1, 32'hc065_a5c3);
		wait_go();
		rc("after wr", OFS_CMD1, 32'h4065_a5c3);
		chk("frame hdr", 32'h0000_14a3, 32'(hdr));
		chk("frame data", 32'h0000_a5c3, 32'(tail[15:0]));
		chk("irq done", 32'h1, 32'(irq_o));
		rc("stat", OFS_STAT, 32'h0000_0001);
		chk("irq clr", 32'h0, 32'(irq_o));
		$display("t_write done");
	endtask : t_write
	task automatic t_read();
		logic [31:0] d;
		wr(OFS_MASKCLR, 32'h0000_0002);
		rc("mask", OFS_MASK, 32'h0000_0002);
		wr(OFS_CMD1, 32'h8065_0000);
		wait_go();
		rc("rd ack", OFS_CMD1, 32'h2065_a5c3);
		wr(OFS_CMD1, 32'h8069_0000);
		wait_go();
		xfer(1'b0, OFS_CMD1, 32'h0, d);
		chk("no ack", 32'h0, 32'(d[ACK_BIT]));
		chk("irq masked", 32'h0, 32'(irq_o));
		rc("stat", OFS_STAT, 32'h0000_0001);
		chk("frames", 32'h0, 32'(bad));
		$display("t_read done");
	endtask : t_read
	task automatic t_link();
		wr(OFS_LINK_SOURCE_SELECT, 32'h0000_0045);
		rc("lsel", OFS_LINK_SOURCE_SELECT, 32'h0000_0045);
		repeat (1300) @(posedge ref_clk_i);
		rc("link dn", OFS_LINK, 32'h0000_0000);
		link_up <= 1'b1;
		repeat (1300) @(posedge ref_clk_i);
		chk("irq link", 32'h1, 32'(irq_o));
		rc("link up", OFS_LINK, 32'h0000_0001);
		rc("stat link", OFS_STAT, 32'h0000_0002);
		wr(OFS_LINK_SOURCE_SELECT, 32'h0000_0005);
		repeat (1300) @(posedge ref_clk_i);
		link_up <= 1'b0;
		repeat (1300) @(posedge ref_clk_i);
		rc("link off", OFS_LINK, 32'h0000_0000);
		rc("stat off", OFS_STAT, 32'h0000_0000);
		chk("irq off", 32'h0, 32'(irq_o));
		$display("t_link done");
	endtask : t_link
	// ------------------------------------------------------------
	// Clock, timeout and main sequence
	// ------------------------------------------------------------
	initial begin
		ref_clk_i = 1'b0;
		forever #10 ref_clk_i = ~ref_clk_i;
	end
	// Ceiling well above the ~9k cycles the scenarios need
	always @(posedge ref_clk_i) begin
		cycles++;
		if (cycles == 40000) begin
			err_count++;
			conclude();
		end
	end
	initial begin
		err_count = 0;
		num_checks = 0;
		cycles = 0;
		sys_rst_i = 1'b1;
		hsel_i = 1'b0;
		haddr_i = 32'h0;
		htrans_i = 2'h0;
		hwrite_i = 1'b0;
		hsize_i = SIZE_WORD;
		hwdata_i = 32'h0;
		link_up = 1'b0;
		repeat (4) @(posedge ref_clk_i);
		sys_rst_i <= 1'b0;
		@(posedge ref_clk_i);
		t_idle();
		t_write();
		t_read();
		t_link();
		conclude();
	end
endmodule : test_mdio_user_access_link_select
`default_nettype wire
